// ==== include/stlx_pkg.sv ====
package stlx_pkg;
  localparam int CI_W = 4;
  // Commands from the layer-2 controller
  localparam logic [3:0] CMD_DEACT_REQ = 4'h0;
  localparam logic [3:0] CMD_SM_CLEAR = 4'h1;
  localparam logic [3:0] CMD_SINGLE_PULSE = 4'h2;
  localparam logic [3:0] CMD_CONT_PULSE = 4'h3;
  localparam logic [3:0] CMD_ACT_REQ = 4'h8;
  localparam logic [3:0] CMD_LOOP_ACT = 4'hA;
  localparam logic [3:0] CMD_DEACT_CONFIRM = 4'hF;
  // Indications to the controller
  localparam logic [3:0] IND_INTERIM_CLOCK = 4'h0;
  localparam logic [3:0] IND_RX_NOT_SYNCED = 4'h4;
  localparam logic [3:0] IND_LINE_ACT = 4'h8;
  localparam logic [3:0] IND_CODE_VIOL = 4'hB;
  localparam logic [3:0] IND_ACT_COMPLETE = 4'hC;
  localparam logic [3:0] IND_DEACT_DONE = 4'hF;
  // Transmitted line infos
  localparam logic [2:0] TX_INFO0 = 3'h0;
  localparam logic [2:0] TX_INFO2 = 3'h2;
  localparam logic [2:0] TX_INFO4 = 3'h4;
  localparam logic [2:0] TX_SINGLE = 3'h5;
  localparam logic [2:0] TX_CONT = 3'h6;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int INFO0_HOLD_MS = 16;
  localparam int DEACT_TIMEOUT_MS = 32;
  localparam int INFO0_HOLD_CYC = INFO0_HOLD_MS * CLK_MHZ * 1000;
  localparam int DEACT_TIMEOUT_CYC = DEACT_TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int TIMER_W = 24;
  typedef enum logic [3:0] {
    STLX_DEACT, STLX_PEND_ACT, STLX_ACTIVE, STLX_LOST_FRAME, STLX_PEND_DEACT,
    STLX_WAIT_DC, STLX_LOOP, STLX_TEST_SINGLE, STLX_TEST_CONT, STLX_CLEARED
  } stlx_state_t;
endpackage

// ==== rtl/stlx_cmd_decode.sv ====
`timescale 1ns/10ps
// Flags defined commands; other codes are ignored
module stlx_cmd_decode
  import stlx_pkg::*;
(
  // Command field
  input wire logic [3:0] cmd,
  // Decoded
  output logic valid,
  output logic test_cmd
);
  function automatic logic is_test(input logic [3:0] c);
    return (c == CMD_SINGLE_PULSE) || (c == CMD_CONT_PULSE);
  endfunction
  always_comb begin
    test_cmd = is_test(cmd);
    case (cmd)
      CMD_DEACT_REQ, CMD_SM_CLEAR, CMD_ACT_REQ, CMD_LOOP_ACT, CMD_DEACT_CONFIRM: valid = 1'b1;
      default: valid = is_test(cmd); // R24
    endcase
  end
endmodule

// ==== rtl/stlx_deact_timer.sv ====
`timescale 1ns/10ps
// Pending-deactivation timers: INFO 0 hold and overall timeout
module stlx_deact_timer
  import stlx_pkg::*;
#(
  parameter int HOLD_CYC = INFO0_HOLD_CYC,
  parameter int TIMEOUT_CYC = DEACT_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic rx_info0,
  // Result
  output logic done
);
  initial begin
    if (HOLD_CYC < 1 || TIMEOUT_CYC < HOLD_CYC || TIMEOUT_CYC >= (1 << TIMER_W))
      $error("stlx_deact_timer: bad counts");
  end
  logic [TIMER_W-1:0] hold_reg, hold_next, tout_reg, tout_next;
  logic done_reg, done_next;
  always_comb begin
    hold_next = '0;
    tout_next = '0;
    done_next = 1'b0;
    if (run) begin
      hold_next = rx_info0 ? hold_reg + 1'b1 : '0;
      tout_next = tout_reg + 1'b1;
      done_next = (rx_info0 && hold_reg >= TIMER_W'(HOLD_CYC - 1)) ||
                  (tout_reg >= TIMER_W'(TIMEOUT_CYC - 1)); // R11
      if (hold_reg == TIMER_W'(HOLD_CYC)) hold_next = hold_reg;
      if (tout_reg == TIMER_W'(TIMEOUT_CYC)) tout_next = tout_reg;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold_reg <= '0;
      tout_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      tout_reg <= tout_next;
      done_reg <= done_next;
    end
  end
  assign done = done_reg;
endmodule

// ==== rtl/stlx_activation_fsm.sv ====
`timescale 1ns/10ps
// Contract
// R01: Test mode from any state but test mode
// R02: Deactivated sends nothing, clock stop option
// R03: Activation by line event or command
// R04: No-signal info or command: send INFO 2
// R05: Software supervises INFO 3 reception time
// R06: Loop command closes analogue loop two
// R07: Activated sends INFO 4 continuously
// R08: Sync loss: lost framing, send INFO 2
// R09: INFO 3 again resumes INFO 4
// R10: Deactivation request: INFO 0, pending deactivation
// R11: Done after 16 ms INFO 0 or 32 ms
// R12: Wait until deactivation confirm
// R13: Confirm enters deactivated, detection enabled
// R14: Clear resets machine, INFO 0, ignores line
// R15: Single or continuous alternating pulse tests
// R16: Controller starts activation with code 1000
// R17: Deactivated reports interim clock indication
// R18: Report not synced when receiver unsynchronous
// R19: Report line activation on no-signal info
// R20: Code violation reported only when enabled
// R21: Activation complete when receiver synchronous
// R22: Controller holds command until action starts
// R23: Indications follow state continuously
// R24: Undefined commands ignored, state kept
module stlx_activation_fsm
  import stlx_pkg::*;
#(
  parameter int HOLD_CYC = INFO0_HOLD_CYC,
  parameter int TIMEOUT_CYC = DEACT_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Controller command/indication field
  input wire logic [3:0] ci_cmd,
  output logic [3:0] ci_ind,
  // Configuration
  input wire logic clock_stop_enable,
  input wire logic code_violation_report_enable,
  // Line receiver status
  input wire logic rx_info0,
  input wire logic rx_level,
  input wire logic rx_info3,
  input wire logic rx_synced,
  input wire logic rx_code_viol,
  // Line transmitter and analogue control
  output logic [2:0] tx_info,
  output logic loop2_close,
  output logic clock_stop,
  output logic line_detect_en
);
  stlx_state_t state_reg, state_next;
  logic [3:0] ind_reg, ind_next;
  logic [2:0] tx_reg, tx_next;
  logic loop_reg, loop_next;
  logic stop_reg, stop_next;
  logic cmd_valid, cmd_test, deact_done, timer_run;

  stlx_cmd_decode u_dec (
    .cmd(ci_cmd),
    .valid(cmd_valid),
    .test_cmd(cmd_test)
  );

  assign timer_run = (state_reg == STLX_PEND_DEACT) && (state_next == STLX_PEND_DEACT);

  stlx_deact_timer #(
    .HOLD_CYC(HOLD_CYC),
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_tmr (
    .clk(clk),
    .nrst(nrst),
    .run(timer_run),
    .rx_info0(rx_info0),
    .done(deact_done)
  );

  // State transitions
  always_comb begin
    state_next = state_reg;
    // Undefined codes act as no command; line events still move the state
    if (cmd_valid && ci_cmd == CMD_SM_CLEAR) begin // R24
      state_next = STLX_CLEARED; // R14
    end else if (cmd_valid && ci_cmd == CMD_DEACT_REQ) begin
      if (state_reg != STLX_PEND_DEACT && state_reg != STLX_WAIT_DC)
        state_next = STLX_PEND_DEACT; // R10
    end else if (cmd_test) begin
      // Only entered from non-test states
      if (state_reg != STLX_TEST_SINGLE && state_reg != STLX_TEST_CONT) // R01
        state_next = (ci_cmd == CMD_SINGLE_PULSE) ? STLX_TEST_SINGLE : STLX_TEST_CONT; // R15
    end else begin
      case (state_reg)
        STLX_DEACT: begin
          if (ci_cmd == CMD_LOOP_ACT)
            state_next = STLX_LOOP; // R06
          else if (ci_cmd == CMD_ACT_REQ || rx_level)
            state_next = STLX_PEND_ACT; // R03 R04 R16
        end
        STLX_PEND_ACT: begin
          if (ci_cmd == CMD_LOOP_ACT)
            state_next = STLX_LOOP; // R06
          else if (rx_info3 && rx_synced)
            state_next = STLX_ACTIVE;
        end
        STLX_ACTIVE: begin
          if (!rx_synced) state_next = STLX_LOST_FRAME; // R08
        end
        STLX_LOST_FRAME: begin
          if (rx_info3 && rx_synced) state_next = STLX_ACTIVE; // R09
        end
        STLX_PEND_DEACT: begin
          if (deact_done) state_next = STLX_WAIT_DC; // R11
        end
        STLX_WAIT_DC, STLX_TEST_SINGLE, STLX_TEST_CONT, STLX_CLEARED: begin
          if (ci_cmd == CMD_DEACT_CONFIRM) state_next = STLX_DEACT; // R12 R13
        end
        STLX_LOOP: begin
          if (ci_cmd == CMD_DEACT_CONFIRM) state_next = STLX_DEACT;
        end
        default: state_next = STLX_CLEARED;
      endcase
    end
  end

  // Outputs follow the next state
  always_comb begin
    tx_next = TX_INFO0;
    loop_next = 1'b0;
    stop_next = 1'b0;
    ind_next = IND_INTERIM_CLOCK;
    case (state_next)
      STLX_DEACT: begin
        tx_next = TX_INFO0; // R02
        stop_next = clock_stop_enable; // R02
        ind_next = rx_level ? IND_LINE_ACT : IND_INTERIM_CLOCK; // R17
      end
      STLX_PEND_ACT: begin
        tx_next = TX_INFO2; // R04
        ind_next = rx_info0 || rx_level ? IND_LINE_ACT : IND_INTERIM_CLOCK; // R19
      end
      STLX_ACTIVE: begin
        tx_next = TX_INFO4; // R07
        ind_next = IND_ACT_COMPLETE; // R21
      end
      STLX_LOST_FRAME: begin
        tx_next = TX_INFO2; // R08
        ind_next = IND_RX_NOT_SYNCED; // R18
      end
      STLX_PEND_DEACT: begin
        tx_next = TX_INFO0; // R10
        ind_next = IND_INTERIM_CLOCK;
      end
      STLX_WAIT_DC: begin
        tx_next = TX_INFO0;
        ind_next = IND_DEACT_DONE; // R11
      end
      STLX_LOOP: begin
        tx_next = TX_INFO2;
        loop_next = 1'b1; // R06
        ind_next = rx_synced ? IND_ACT_COMPLETE : IND_RX_NOT_SYNCED;
      end
      STLX_TEST_SINGLE: tx_next = TX_SINGLE; // R15
      STLX_TEST_CONT: tx_next = TX_CONT; // R15
      STLX_CLEARED: tx_next = TX_INFO0; // R14
      default: tx_next = TX_INFO0;
    endcase
    // Line-derived indications are held off while cleared, in test or waiting for deactivation confirm
    if (state_next != STLX_CLEARED && state_next != STLX_TEST_SINGLE &&
        state_next != STLX_TEST_CONT && state_next != STLX_WAIT_DC) begin
      if (code_violation_report_enable && rx_code_viol)
        ind_next = IND_CODE_VIOL; // R20
      else if (state_next == STLX_PEND_ACT && rx_level && !rx_synced && !rx_info0)
        ind_next = IND_RX_NOT_SYNCED; // R18
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= STLX_CLEARED;
      ind_reg <= IND_INTERIM_CLOCK;
      tx_reg <= TX_INFO0;
      loop_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ind_reg <= ind_next; // R23
      tx_reg <= tx_next;
      loop_reg <= loop_next;
      stop_reg <= stop_next;
    end
  end

  assign ci_ind = ind_reg;
  assign tx_info = tx_reg;
  assign loop2_close = loop_reg;
  assign clock_stop = stop_reg;
  assign line_detect_en = (state_reg == STLX_DEACT); // R13
endmodule

// ==== tb/stlx_fsm_properties.sv ====
`timescale 1ns/10ps
module stlx_fsm_properties
  import stlx_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Watched ports
  input wire logic [3:0] ci_cmd,
  input wire logic [3:0] ci_ind,
  input wire logic rx_synced,
  input wire logic [2:0] tx_info,
  input wire logic loop2_close,
  input wire logic line_detect_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  deact_req_a: assert property (ci_cmd == CMD_DEACT_REQ && tx_info == TX_INFO4
    |=> tx_info == TX_INFO0) else $error("no INFO 0 after deactivation");
  sm_clear_a: assert property (ci_cmd == CMD_SM_CLEAR
    |=> tx_info == TX_INFO0 && !loop2_close) else $error("clear failed");
  pulse_test_a: assert property (ci_cmd == CMD_SINGLE_PULSE && tx_info != TX_CONT
    |=> tx_info == TX_SINGLE) else $error("no single pulses");
  act_start_a: assert property (line_detect_en && ci_cmd == CMD_ACT_REQ
    |=> tx_info == TX_INFO2) else $error("no INFO 2");
  lost_frame_a: assert property (tx_info == TX_INFO4 && !rx_synced
    && !(ci_cmd inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hA})
    |=> tx_info == TX_INFO2) else $error("no INFO 2 on sync loss");
  wait_hold_a: assert property (ci_ind == IND_DEACT_DONE
    && ci_cmd inside {4'h0, [4'h4:4'h9], [4'hB:4'hE]}
    |=> ci_ind == IND_DEACT_DONE) else $error("left wait state");
  confirm_a: assert property (ci_ind == IND_DEACT_DONE && ci_cmd == CMD_DEACT_CONFIRM
    |=> line_detect_en) else $error("confirm ignored");
  deact_quiet_a: assert property (line_detect_en
    |-> tx_info == TX_INFO0 && !loop2_close) else $error("sending while deactivated");
endmodule

// ==== tb/stlx_te_model.sv ====
`timescale 1ns/10ps
module stlx_te_model
  import stlx_pkg::*;
#(
  parameter int DLY = 3
) (
  // Clock and line from the device
  input wire logic clk,
  input wire logic [2:0] tx_info,
  // Behaviour controls
  input wire logic wake,
  input wire logic resp,
  input wire logic silent,
  input wire logic nosync,
  input wire logic viol,
  // Receiver status
  output logic rx_info0,
  output logic rx_level,
  output logic rx_info3,
  output logic rx_synced,
  output logic rx_code_viol
);
  int cnt = 0;
  // INFO 3 follows INFO 2 after a short delay
  always @(posedge clk) begin
    if (resp && (tx_info == TX_INFO2 || tx_info == TX_INFO4)) begin
      cnt <= (cnt < DLY) ? cnt + 1 : cnt;
    end else begin
      cnt <= 0;
    end
  end
  assign rx_info3 = (cnt == DLY) && !nosync;
  assign rx_synced = rx_info3;
  assign rx_info0 = silent;
  assign rx_level = wake;
  assign rx_code_viol = viol;
endmodule

// ==== tb/stlx_activation_fsm_tb.sv ====
`timescale 1ns/10ps
module stlx_activation_fsm_tb;
  import stlx_pkg::*;
  localparam int HOLD = 20;
  localparam int TMO = 40;
  logic clk = 0, nrst = 0, cse = 0, cve = 0, wake = 0, resp = 0, silent = 0, nosync = 0;
  logic viol = 0, rx_info0, rx_level, rx_info3, rx_synced, rx_code_viol, loop2, cstop, lde;
  logic [3:0] ci_cmd = 4'h7, ci_ind;
  logic [2:0] tx_info;
  int n_fail = 0, checks = 0, n;
  initial forever #2 clk = ~clk;
  stlx_activation_fsm #(.HOLD_CYC(HOLD), .TIMEOUT_CYC(TMO)) dut (.clk(clk), .nrst(nrst),
    .ci_cmd(ci_cmd), .ci_ind(ci_ind), .clock_stop_enable(cse),
    .code_violation_report_enable(cve), .rx_info0(rx_info0), .rx_level(rx_level),
    .rx_info3(rx_info3), .rx_synced(rx_synced), .rx_code_viol(rx_code_viol),
    .tx_info(tx_info), .loop2_close(loop2), .clock_stop(cstop), .line_detect_en(lde));
  stlx_te_model te (.clk(clk), .tx_info(tx_info), .wake(wake), .resp(resp), .silent(silent),
    .nosync(nosync), .viol(viol), .rx_info0(rx_info0), .rx_level(rx_level),
    .rx_info3(rx_info3), .rx_synced(rx_synced), .rx_code_viol(rx_code_viol));
  task test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Held over the taking edge, then an undefined code
  task cmd(input logic [3:0] c);
    @(negedge clk) ci_cmd = c;
    @(negedge clk) ci_cmd = 4'h7;
  endtask
  task wt(input logic [3:0] e, input bit ind, input int lim);
    n = 0;
    while ((ind ? ci_ind : {1'b0, tx_info}) !== e && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(ind ? ci_ind : {1'b0, tx_info}, e);
    if ((ind ? ci_ind : {1'b0, tx_info}) !== e) test_done;
  endtask
  task t_reset;
    chk({1'b0, tx_info}, 4'h0);
    cmd(CMD_DEACT_CONFIRM);
    chk({3'h0, lde}, 4'h1);
    chk(ci_ind, IND_INTERIM_CLOCK);
    cse = 1;
    repeat (2) @(negedge clk);
    chk({3'h0, cstop}, 4'h1);
    cse = 0;
    @(negedge clk);
    chk({3'h0, cstop}, 4'h0);
    $display("t_reset done");
  endtask
  task t_line;
    wake = 1;
    silent = 1;
    wt({1'b0, TX_INFO2}, 0, 4);
    chk(ci_ind, IND_LINE_ACT);
    silent = 0;
    @(negedge clk);
    chk(ci_ind, IND_RX_NOT_SYNCED);
    wake = 0;
    resp = 1;
    wt({1'b0, TX_INFO4}, 0, 10);
    cmd(CMD_SM_CLEAR);
    chk({1'b0, tx_info}, 4'h0);
    resp = 0;
    // Line events must not wake a cleared machine
    wake = 1;
    repeat (2) @(negedge clk);
    chk({1'b0, tx_info}, 4'h0);
    wake = 0;
    cmd(CMD_DEACT_CONFIRM);
    $display("t_line done");
  endtask
  task t_act;
    cmd(CMD_ACT_REQ);
    chk({1'b0, tx_info}, {1'b0, TX_INFO2});
    resp = 1;
    wt(IND_ACT_COMPLETE, 1, 10);
    nosync = 1;
    wt({1'b0, TX_INFO2}, 0, 4);
    chk(ci_ind, IND_RX_NOT_SYNCED);
    nosync = 0;
    wt({1'b0, TX_INFO4}, 0, 4);
    viol = 1;
    cve = 1;
    wt(IND_CODE_VIOL, 1, 4);
    cve = 0;
    wt(IND_ACT_COMPLETE, 1, 4);
    viol = 0;
    cmd(4'h5);
    chk({1'b0, tx_info}, {1'b0, TX_INFO4});
    chk(ci_ind, IND_ACT_COMPLETE);
    $display("t_act done");
  endtask
  task t_deact(input logic s, input int lim);
    silent = s;
    cmd(CMD_DEACT_REQ);
    chk({1'b0, tx_info}, 4'h0);
    wt(IND_DEACT_DONE, 1, lim + 6);
    chk({3'h0, n >= lim - 3}, 4'h1);
    cmd(4'h4);
    chk(ci_ind, IND_DEACT_DONE);
    silent = 0;
    cmd(CMD_DEACT_CONFIRM);
    chk({3'h0, lde}, 4'h1);
    $display("t_deact done");
  endtask
  task t_modes;
    resp = 0;
    cmd(CMD_LOOP_ACT);
    chk({3'h0, loop2}, 4'h1);
    cmd(CMD_SINGLE_PULSE);
    chk({1'b0, tx_info}, {1'b0, TX_SINGLE});
    cmd(CMD_CONT_PULSE);
    chk({1'b0, tx_info}, {1'b0, TX_SINGLE});
    cmd(CMD_SM_CLEAR);
    chk({3'h0, loop2}, 4'h0);
    cmd(CMD_CONT_PULSE);
    chk({1'b0, tx_info}, {1'b0, TX_CONT});
    $display("t_modes done");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1;
    t_reset();
    t_line();
    t_act();
    t_deact(1, HOLD);
    t_deact(0, TMO);
    t_modes();
    test_done();
  end
endmodule
bind stlx_activation_fsm stlx_fsm_properties props (.clk(clk), .nrst(nrst), .ci_cmd(ci_cmd),
  .ci_ind(ci_ind), .rx_synced(rx_synced), .tx_info(tx_info), .loop2_close(loop2_close),
  .line_detect_en(line_detect_en));
